// *** src/pplh_link.sv ***
// Purpose: Local handshake, unescape and check of serial link frames
// Assumes: Serial bytes come from a UART on clk_sys; network side is a byte stream
// Notes: One frame store holds the network frame for retransmission
`timescale 1ns/1ps
module pplh_link
  import pplh_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int MS_CYCLES = PPLH_MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic ser_rx_valid,
  input wire logic [7:0] ser_rx_data,
  output logic ser_tx_valid,
  output logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  output logic net_rx_valid,
  output logic [7:0] net_rx_data,
  output logic net_rx_end,
  output logic net_rx_bad,
  input wire logic net_in_valid,
  input wire logic [7:0] net_in_data,
  input wire logic net_in_last,
  output logic net_in_ready
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(MS_CYCLES);

  // Refuse parameters the logic cannot serve:
  // prescaler and frame store need two entries at least
  if (DEPTH < 2 || MS_CYCLES < 2) begin : g_param_check
    $error("pplh_link: DEPTH and MS_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  pplh_state_t state_reg;
  logic [3:0] ctrl_reg;
  logic [7:0] apos_reg;
  logic [12:0] tmo_reg;
  logic [2:0] retries_reg;
  logic [3:0] irq_st_reg;
  logic [3:0] irq_mask_reg;
  logic [15:0] paddr_reg;
  logic [15:0] rdata_reg;
  logic irq_reg;
  logic [7:0] mem_reg [DEPTH];
  logic [CW-1:0] wcnt_reg;
  logic [CW-1:0] rd_idx_reg;
  logic tx_pend_reg;
  logic in_ready_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic [1:0] phase_reg;
  logic dup_reg;
  logic [7:0] tx_bcc_reg;
  logic [7:0] rx_bcc_reg;
  logic esc_reg;
  logic [7:0] pidx_reg;
  logic [2:0] retry_cnt_reg;
  logic [PW-1:0] pre_reg;
  logic [12:0] ms_reg;
  logic out_valid_reg;
  logic [7:0] out_data_reg;
  logic out_end_reg;
  logic out_bad_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of received bytes and events
  wire [7:0] b = ser_rx_data;
  wire bcc_en = ctrl_reg[PPLH_C_BCC];
  wire prio_hi = ctrl_reg[PPLH_C_PRIO];
  wire [1:0] amode = ctrl_reg[PPLH_C_MODE +: 2];
  wire is_dle = ser_rx_valid & (b == PPLH_DLE);
  wire is_stx = ser_rx_valid & (b == PPLH_STX);
  wire in_rx = (state_reg == PPLH_RX) & ser_rx_valid;
  wire in_bcc = (state_reg == PPLH_RX_BCC) & ser_rx_valid;
  wire waiting = (state_reg == PPLH_TX_W1) | (state_reg == PPLH_TX_W2);
  wire tx_free = ~tx_valid_reg | ser_tx_ready;
  wire pay_ok = in_rx & (esc_reg ? (b == PPLH_DLE) : (b != PPLH_DLE));
  wire end_etx = in_rx & esc_reg & (b == PPLH_ETX);
  wire ev_rx_ok = (end_etx & ~bcc_en) | (in_bcc & (b == rx_bcc_reg));
  wire ev_rx_bad = (in_rx & esc_reg & (b != PPLH_DLE) & (b != PPLH_ETX))
                 | (in_bcc & (b != rx_bcc_reg));
  wire ev_tx_ok = (state_reg == PPLH_TX_W2) & is_dle;
  // Received byte beats a coinciding timeout
  wire tmo_end = waiting & (ms_reg >= tmo_reg) & ~ser_rx_valid;
  wire ev_tx_fail = tmo_end & (retry_cnt_reg >= retries_reg);
  wire tx_release = ev_tx_ok | ev_tx_fail;
  wire ms_tick = (pre_reg == PW'(MS_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  wire wr_ctrl = reg_wr & (reg_addr == PPLH_R_CTRL);
  wire wr_apos = reg_wr & (reg_addr == PPLH_R_APOS);
  wire wr_tmo = reg_wr & (reg_addr == PPLH_R_TMO);
  wire wr_retry = reg_wr & (reg_addr == PPLH_R_RETRY);
  wire wr_irq = reg_wr & (reg_addr == PPLH_R_IRQ);
  wire wr_mask = reg_wr & (reg_addr == PPLH_R_MASK);
  wire [12:0] tmo_w = reg_wdata[12:0];
  wire big_w = (reg_wdata[15:13] != 3'h0) | (tmo_w > PPLH_TMO_MAX);
  wire [12:0] tmo_clamp = big_w ? PPLH_TMO_MAX :
                          (tmo_w < PPLH_TMO_MIN) ? PPLH_TMO_MIN : tmo_w;
  wire [3:0] ev_vec = {ev_tx_fail, ev_tx_ok, ev_rx_bad, ev_rx_ok};
  wire [3:0] irq_clr = wr_irq ? reg_wdata[3:0] : 4'h0;
  // Set wins over write-one clear
  wire [3:0] irq_next = (irq_st_reg & ~irq_clr) | ev_vec;
  wire busy = (state_reg != PPLH_IDLE);
  wire [15:0] stat_v = {11'h000, retry_cnt_reg, tx_pend_reg, busy};
  wire [15:0] rd_mux =
    (reg_addr == PPLH_R_CTRL) ? {12'h000, ctrl_reg} :
    (reg_addr == PPLH_R_APOS) ? {8'h00, apos_reg} :
    (reg_addr == PPLH_R_TMO) ? {3'h0, tmo_reg} :
    (reg_addr == PPLH_R_RETRY) ? {13'h0000, retries_reg} :
    (reg_addr == PPLH_R_STAT) ? stat_v :
    (reg_addr == PPLH_R_IRQ) ? {12'h000, irq_st_reg} :
    (reg_addr == PPLH_R_MASK) ? {12'h000, irq_mask_reg} :
    (reg_addr == PPLH_R_ADDR) ? paddr_reg : 16'h0000;

  // Configuration registers; timeout clamped to its legal range
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= PPLH_CTRL_RST;
      apos_reg <= PPLH_APOS_RST;
      tmo_reg <= PPLH_TMO_RST;
      retries_reg <= PPLH_RETRY_RST;
      irq_mask_reg <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata[3:0];
      if (wr_apos) apos_reg <= reg_wdata[7:0];
      if (wr_tmo) tmo_reg <= tmo_clamp;
      if (wr_retry) retries_reg <= reg_wdata[2:0];
      if (wr_mask) irq_mask_reg <= reg_wdata[3:0];
    end
  end

  // Read data, sticky status and interrupt line
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
      irq_st_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 16'h0000;
      irq_st_reg <= irq_next;
      irq_reg <= |(irq_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame store for the network frame, kept until acknowledged or abandoned
  wire in_acc = net_in_valid & in_ready_reg;
  wire fill_end = in_acc & (net_in_last | (wcnt_reg == CW'(DEPTH - 1)));
  wire ready_next = tx_release | ~(tx_pend_reg | fill_end);

  always_ff @(posedge clk_sys) begin
    if (in_acc) mem_reg[wcnt_reg[$clog2(DEPTH)-1:0]] <= net_in_data;
  end

  // Over-long frames are cut at DEPTH bytes rather than stalling forever
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wcnt_reg <= '0;
      tx_pend_reg <= 1'b0;
      in_ready_reg <= 1'b0;
    end else begin
      in_ready_reg <= ready_next;
      if (tx_release) begin
        wcnt_reg <= '0;
        tx_pend_reg <= 1'b0;
      end else begin
        if (in_acc) wcnt_reg <= wcnt_reg + CW'(1);
        if (fill_end) tx_pend_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond timer for DLE wait, restarted on each wait
  always_ff @(posedge clk_sys) begin
    if (!resetn || !waiting) begin
      pre_reg <= '0;
      ms_reg <= 13'h0000;
    end else begin
      pre_reg <= ms_tick ? '0 : pre_reg + PW'(1);
      if (ms_tick && ms_reg != PPLH_TMO_MAX) ms_reg <= ms_reg + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // payload index from 1, stuffing bytes excluded
  wire [7:0] pnew = pidx_reg + 8'h01;
  wire [7:0] apos1 = apos_reg + 8'h01;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pidx_reg <= 8'h00;
      paddr_reg <= 16'h0000;
    end else if (state_reg == PPLH_RX_ACK1) begin
      pidx_reg <= 8'h00;
    end else if (pay_ok) begin
      pidx_reg <= pnew;
      if (pnew == apos_reg) begin
        case (amode)
          PPLH_AM_LSB: paddr_reg[7:0] <= b;
          PPLH_AM_MSB: paddr_reg[15:8] <= b;
          default: paddr_reg <= {8'h00, b};
        endcase
      end else if (pnew == apos1) begin
        if (amode == PPLH_AM_LSB) paddr_reg[15:8] <= b;
        if (amode == PPLH_AM_MSB) paddr_reg[7:0] <= b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // only unescaped payload and frame end reach the network
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 8'h00;
      out_end_reg <= 1'b0;
      out_bad_reg <= 1'b0;
    end else begin
      out_valid_reg <= pay_ok;
      if (pay_ok) out_data_reg <= b;
      out_end_reg <= ev_rx_ok | ev_rx_bad;
      out_bad_reg <= ev_rx_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing block byte: stuffed data, then DLE, ETX and check byte
  wire [7:0] mem_byte = mem_reg[rd_idx_reg[$clog2(DEPTH)-1:0]];
  wire [7:0] body_byte = dup_reg ? PPLH_DLE :
                         (phase_reg == 2'h0) ? mem_byte :
                         (phase_reg == 2'h1) ? PPLH_DLE :
                         (phase_reg == 2'h2) ? PPLH_ETX : tx_bcc_reg;
  wire body_go = (state_reg == PPLH_TX_BODY) & tx_free;
  wire last_data = (rd_idx_reg == wcnt_reg - CW'(1));

  // Link sequencer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= PPLH_IDLE;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      phase_reg <= 2'h0;
      dup_reg <= 1'b0;
      rd_idx_reg <= '0;
      tx_bcc_reg <= 8'h00;
      rx_bcc_reg <= 8'h00;
      esc_reg <= 1'b0;
      retry_cnt_reg <= 3'h0;
    end else begin
      if (tx_free) tx_valid_reg <= 1'b0;
      case (state_reg)
        PPLH_IDLE: begin
          if (is_stx) begin
            state_reg <= PPLH_RX_ACK1;
          end else if (tx_pend_reg) begin
            state_reg <= PPLH_TX_STX;
          end
        end
        PPLH_RX_ACK1: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= PPLH_DLE;
            rx_bcc_reg <= 8'h00;
            esc_reg <= 1'b0;
            state_reg <= PPLH_RX;
          end
        end
        PPLH_RX: begin
          if (ser_rx_valid) begin
            // XOR over every received block byte
            rx_bcc_reg <= rx_bcc_reg ^ b;
            esc_reg <= ~esc_reg & (b == PPLH_DLE);
            if (end_etx) begin
              state_reg <= bcc_en ? PPLH_RX_BCC : PPLH_RX_ACK2;
            end else if (ev_rx_bad) begin
              state_reg <= PPLH_IDLE;
            end
          end
        end
        PPLH_RX_BCC: begin
          // no DLE on a bad check byte
          if (ser_rx_valid) state_reg <= ev_rx_ok ? PPLH_RX_ACK2 : PPLH_IDLE;
        end
        PPLH_RX_ACK2: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= PPLH_DLE;
            state_reg <= PPLH_IDLE;
          end
        end
        PPLH_TX_STX: begin
          if (tx_free) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= PPLH_STX;
            state_reg <= PPLH_TX_W1;
          end
        end
        PPLH_TX_W1: begin
          if (is_dle) begin
            rd_idx_reg <= '0;
            dup_reg <= 1'b0;
            tx_bcc_reg <= 8'h00;
            phase_reg <= (wcnt_reg == '0) ? 2'h1 : 2'h0;
            state_reg <= PPLH_TX_BODY;
          end else if (is_stx && !prio_hi) begin
            // low priority yields and receives first
            state_reg <= PPLH_RX_ACK1;
          end else if (tmo_end) begin
            state_reg <= ev_tx_fail ? PPLH_IDLE : PPLH_TX_STX;
            retry_cnt_reg <= ev_tx_fail ? 3'h0 : retry_cnt_reg + 3'h1;
          end
        end
        PPLH_TX_BODY: begin
          if (body_go) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg <= body_byte;
            // check byte covers stuffing, DLE and ETX
            if (phase_reg != 2'h3) tx_bcc_reg <= tx_bcc_reg ^ body_byte;
            case (phase_reg)
              2'h0: begin
                if (body_byte == PPLH_DLE && !dup_reg) begin
                  dup_reg <= 1'b1;
                end else begin
                  dup_reg <= 1'b0;
                  rd_idx_reg <= rd_idx_reg + CW'(1);
                  if (last_data) phase_reg <= 2'h1;
                end
              end
              2'h1: phase_reg <= 2'h2;
              // check byte built here, not taken from the network
              2'h2: begin
                if (bcc_en) phase_reg <= 2'h3;
                else state_reg <= PPLH_TX_W2;
              end
              default: state_reg <= PPLH_TX_W2;
            endcase
          end
        end
        PPLH_TX_W2: begin
          if (ev_tx_ok) begin
            retry_cnt_reg <= 3'h0;
            state_reg <= PPLH_IDLE;
          end else if (tmo_end) begin
            state_reg <= ev_tx_fail ? PPLH_IDLE : PPLH_TX_STX;
            retry_cnt_reg <= ev_tx_fail ? 3'h0 : retry_cnt_reg + 3'h1;
          end
        end
        default: state_reg <= PPLH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
  assign ser_tx_valid = tx_valid_reg;
  assign ser_tx_data = tx_data_reg;
  assign net_rx_valid = out_valid_reg;
  assign net_rx_data = out_data_reg;
  assign net_rx_end = out_end_reg;
  assign net_rx_bad = out_bad_reg;
  assign net_in_ready = in_ready_reg;
endmodule

// *** inc/pplh_pkg.sv ***
// Purpose: Shared constants for the point-to-point link handshake block
// Assumes: Byte-wide serial side, 16-bit register port
// Notes: Register offsets are word indexes on the plain register port
package pplh_pkg;
  // Link control bytes
  localparam logic [7:0] PPLH_STX = 8'h02;
  localparam logic [7:0] PPLH_ETX = 8'h03;
  localparam logic [7:0] PPLH_DLE = 8'h10;
  // Register indexes
  localparam logic [3:0] PPLH_R_CTRL = 4'h0;
  localparam logic [3:0] PPLH_R_APOS = 4'h1;
  localparam logic [3:0] PPLH_R_TMO = 4'h2;
  localparam logic [3:0] PPLH_R_RETRY = 4'h3;
  localparam logic [3:0] PPLH_R_STAT = 4'h4;
  localparam logic [3:0] PPLH_R_IRQ = 4'h5;
  localparam logic [3:0] PPLH_R_MASK = 4'h6;
  localparam logic [3:0] PPLH_R_ADDR = 4'h7;
  // Control fields
  localparam int PPLH_C_BCC = 0;
  localparam int PPLH_C_PRIO = 1;
  localparam int PPLH_C_MODE = 2;
  localparam logic [3:0] PPLH_CTRL_RST = 4'h1;
  localparam logic [1:0] PPLH_AM_1B = 2'h0;
  localparam logic [1:0] PPLH_AM_LSB = 2'h1;
  localparam logic [1:0] PPLH_AM_MSB = 2'h2;
  localparam logic [7:0] PPLH_APOS_RST = 8'h01;
  // Response timeout in ms and retries
  localparam logic [12:0] PPLH_TMO_RST = 13'h03E8;
  localparam logic [12:0] PPLH_TMO_MIN = 13'h012C;
  localparam logic [12:0] PPLH_TMO_MAX = 13'h1FFE;
  localparam logic [2:0] PPLH_RETRY_RST = 3'h3;
  // Interrupt bits
  localparam int PPLH_I_RXOK = 0;
  localparam int PPLH_I_RXBAD = 1;
  localparam int PPLH_I_TXOK = 2;
  localparam int PPLH_I_TXFAIL = 3;
  // Millisecond tick from the 5 ns clock
  localparam int PPLH_MS_NS = 1000000;
  localparam int PPLH_CLK_NS = 5;
  localparam int PPLH_MS_CYCLES = PPLH_MS_NS / PPLH_CLK_NS;
  typedef enum logic [3:0] {
    PPLH_IDLE, PPLH_RX_ACK1, PPLH_RX, PPLH_RX_BCC, PPLH_RX_ACK2,
    PPLH_TX_STX, PPLH_TX_W1, PPLH_TX_BODY, PPLH_TX_W2
  } pplh_state_t;
endpackage

// *** test/pplh_link_sva.sv ***
// Purpose: Port assertions for the link handshake block
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only top-level ports, so frame state is inferred from pulses
`timescale 1ns/1ps
module pplh_link_sva
  import pplh_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic irq,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_ready,
  input wire logic net_rx_end,
  input wire logic net_rx_bad,
  input wire logic net_in_valid,
  input wire logic net_in_last,
  input wire logic net_in_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire dle_out = ser_tx_valid && ser_tx_data == PPLH_DLE;
  ////////////////////////////////////////////////////////////////////////////
  // Mask cleared and left alone for three cycles
  sequence s_mask_off;
    reg_wr && reg_addr == PPLH_R_MASK && reg_wdata[3:0] == 4'h0
      ##1 !(reg_wr && reg_addr == PPLH_R_MASK) [*3];
  endsequence
  // Register port
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (s_mask_off |-> !irq)
    else $error("irq high with all sources masked");
  // Serial and network sides
  a_tx_hold: assert property (
    ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data))
    else $error("serial byte changed before taken");
  a_end_single: assert property (net_rx_end |=> !net_rx_end)
    else $error("frame end longer than one cycle");
  a_bad_in_end: assert property (net_rx_bad |-> net_rx_end)
    else $error("bad flag without frame end");
  a_good_acked: assert property (net_rx_end && !net_rx_bad |-> ##[0:3] dle_out)
    else $error("good frame not acknowledged");
  a_bad_no_ack: assert property (net_rx_end && net_rx_bad |-> (!dle_out) [*4])
    else $error("bad frame acknowledged");
  a_ready_drop: assert property (
    net_in_valid && net_in_ready && net_in_last |=> !net_in_ready)
    else $error("network ready after last byte");
endmodule
bind pplh_link pplh_link_sva u_sva (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .irq, .ser_tx_valid, .ser_tx_data, .ser_tx_ready, .net_rx_end,
  .net_rx_bad, .net_in_valid, .net_in_last, .net_in_ready);

// *** test/pplh_ctrl_model.sv ***
// Purpose: Behavioural controller on the serial side of the link block
// Assumes: Byte view of the UART on clk_sys
// Notes: A 0x02 data byte would be taken for STX; benches avoid it
`timescale 1ns/1ps
module pplh_ctrl_model
  import pplh_pkg::*;
(
  input wire logic clk_sys,
  input wire logic ack_en,
  input wire logic slow,
  input wire logic ser_tx_valid,
  input wire logic [7:0] ser_tx_data,
  output logic ser_tx_ready,
  output logic ser_rx_valid,
  output logic [7:0] ser_rx_data
);
  logic [7:0] seen_q[$];
  logic esc = 1'b0;
  logic etx = 1'b0;
  int reply = 0;
  initial begin
    ser_tx_ready = 1'b1;
    ser_rx_valid = 1'b0;
    ser_rx_data = 8'h00;
  end
  // One byte; released line shows the inverse, not a stale copy
  task automatic send(input logic [7:0] b);
    ser_rx_valid <= 1'b1;
    ser_rx_data <= b;
    @(posedge clk_sys);
    ser_rx_valid <= 1'b0;
    ser_rx_data <= ~b;
    @(posedge clk_sys);
  endtask
  // Slow mode drops ready on every other cycle
  always @(posedge clk_sys) ser_tx_ready <= slow ? ~ser_tx_ready : 1'b1;
  always @(posedge clk_sys) begin
    if (ser_tx_valid && ser_tx_ready) begin
      seen_q.push_back(ser_tx_data);
      if (etx) begin
        etx <= 1'b0;
        reply += ack_en;
      end else if (ser_tx_data == PPLH_STX) begin
        esc <= 1'b0;
        reply += ack_en;
      end else if (esc) begin
        esc <= 1'b0;
        etx <= ser_tx_data == PPLH_ETX;
      end else begin
        esc <= ser_tx_data == PPLH_DLE;
      end
    end
  end
  always @(posedge clk_sys) begin
    if (reply > 0) begin
      reply--;
      repeat (slow ? 40 : 3) @(posedge clk_sys);
      send(PPLH_DLE);
    end
  end
endmodule

// *** test/pplh_link_tb_top.sv ***
// Purpose: Self-checking bench for the link handshake block
// Assumes: Millisecond tick shortened to 4 cycles
// Notes: The rx, bad, tx and collision tests wait on the controller model's byte log
`timescale 1ns/1ps
module pplh_link_tb_top
  import pplh_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq, ser_rx_valid, ser_tx_valid, ser_tx_ready, net_rx_valid, net_rx_end, net_rx_bad;
  logic [7:0] ser_rx_data, ser_tx_data, net_rx_data;
  logic net_in_valid = 1'b0;
  logic [7:0] net_in_data = 8'h00;
  logic net_in_last = 1'b0;
  logic net_in_ready, end_bad;
  logic ack_en = 1'b1;
  logic slow = 1'b0;
  logic no_bcc = 1'b0;
  logic [7:0] netq[$];
  logic [7:0] exp_q[$];
  int fails = 0;
  int n_compared = 0;
  always #2.5 clk_sys = ~clk_sys;
  pplh_link #(.MS_CYCLES(4)) u_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .ser_rx_valid, .ser_rx_data, .ser_tx_valid, .ser_tx_data,
    .ser_tx_ready, .net_rx_valid, .net_rx_data, .net_rx_end, .net_rx_bad, .net_in_valid,
    .net_in_data, .net_in_last, .net_in_ready);
  pplh_ctrl_model u_ctrl (.clk_sys, .ack_en, .slow, .ser_tx_valid, .ser_tx_data,
    .ser_tx_ready, .ser_rx_valid, .ser_rx_data);
  // Log forwarded payload
  always @(posedge clk_sys) begin
    if (net_rx_valid) netq.push_back(net_rx_data);
    if (net_rx_end) end_bad = net_rx_bad;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  task automatic wait_seen(input int n);
    for (int k = 0; k < 4000 && u_ctrl.seen_q.size() < n; k++) @(posedge clk_sys);
  endtask
  // Body, doubled DLEs, DLE ETX and check byte; bad flips bit 0 of the check byte
  task automatic ctl_block(input logic [7:0] pl[$], input logic bad);
    logic [7:0] bcc;
    bcc = PPLH_DLE ^ PPLH_ETX ^ {7'h00, bad};
    foreach (pl[i]) begin
      u_ctrl.send(pl[i]);
      bcc ^= pl[i];
      if (pl[i] == PPLH_DLE) begin
        u_ctrl.send(PPLH_DLE);
        bcc ^= PPLH_DLE;
      end
    end
    u_ctrl.send(PPLH_DLE);
    u_ctrl.send(PPLH_ETX);
    if (!no_bcc) u_ctrl.send(bcc);
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic rx_frame(input logic [7:0] pl[$], input logic bad);
    netq.delete();
    u_ctrl.seen_q.delete();
    end_bad = 1'bx;
    u_ctrl.send(PPLH_STX);
    wait_seen(1);
    ctl_block(pl, bad);
    chk("rx bad flag", {15'h0000, end_bad}, {15'h0000, bad});
    chk("rx dle count", u_ctrl.seen_q.size(), bad ? 16'h0001 : 16'h0002);
    chk("rx dle", u_ctrl.seen_q[0], PPLH_DLE);
    chk("rx len", netq.size(), pl.size());
    foreach (pl[i]) chk("rx data", netq[i], pl[i]);
  endtask
  task automatic send_net(input logic [7:0] pl[$]);
    foreach (pl[i]) begin
      net_in_valid <= 1'b1;
      net_in_data <= pl[i];
      net_in_last <= i == pl.size() - 1;
      @(posedge clk_sys);
      while (net_in_ready !== 1'b1) @(posedge clk_sys);
    end
    net_in_valid <= 1'b0;
    net_in_last <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk("ctrl", PPLH_R_CTRL, 16'h0001);
    rd_chk("apos", PPLH_R_APOS, 16'h0001);
    rd_chk("tmo", PPLH_R_TMO, 16'h03E8);
    rd_chk("retry", PPLH_R_RETRY, 16'h0003);
    rd_chk("mask", PPLH_R_MASK, 16'h0000);
    rd_chk("hole", 4'h9, 16'h0000);
    wr(PPLH_R_TMO, 16'h0005);
    rd_chk("tmo low", PPLH_R_TMO, 16'h012C);
    wr(PPLH_R_TMO, 16'h1FFF);
    rd_chk("tmo high", PPLH_R_TMO, 16'h1FFE);
    wr(PPLH_R_RETRY, 16'h0007);
    rd_chk("retry max", PPLH_R_RETRY, 16'h0007);
    wr(PPLH_R_TMO, 16'h012C);
    $display("test regs done");
  endtask
  // Escaped byte is the first address byte; every address layout
  task automatic t_rx();
    logic [15:0] ea[4];
    ea = '{16'h0010, 16'h3310, 16'h1033, 16'h0010};
    wr(PPLH_R_APOS, 16'h0002);
    // Mode 3 falls back to the one-byte layout
    for (int m = 0; m < 4; m++) begin
      wr(PPLH_R_CTRL, {12'h000, m[1:0], 2'b01});
      rx_frame('{8'h5A, 8'h10, 8'h33, 8'h04}, 1'b0);
      rd_chk("addr", PPLH_R_ADDR, ea[m]);
    end
    // Check byte off: block ends at DLE ETX
    wr(PPLH_R_CTRL, 16'h0000);
    no_bcc = 1'b1;
    rx_frame('{8'h5A}, 1'b0);
    no_bcc = 1'b0;
    wr(PPLH_R_CTRL, 16'h0001);
    rd_chk("irq rx", PPLH_R_IRQ, 16'h0001);
    $display("test rx done");
  endtask
  task automatic t_bad();
    wr(PPLH_R_IRQ, 16'h000F);
    wr(PPLH_R_MASK, 16'h0002);
    rx_frame('{8'h10, 8'h10, 8'h7E}, 1'b1);
    chk("irq line", {15'h0000, irq}, 16'h0001);
    rd_chk("irq bad", PPLH_R_IRQ, 16'h0002);
    wr(PPLH_R_MASK, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr(PPLH_R_IRQ, 16'h0002);
    rd_chk("irq clear", PPLH_R_IRQ, 16'h0000);
    $display("test bad check byte done");
  endtask
  // Stalling controller, slow DLE answers
  task automatic t_tx();
    logic [7:0] pl[$];
    logic [7:0] b;
    pl = '{8'h10, 8'h44, 8'h03};
    exp_q = '{PPLH_STX};
    b = 8'h00;
    foreach (pl[i]) begin
      exp_q.push_back(pl[i]);
      if (pl[i] == PPLH_DLE) exp_q.push_back(PPLH_DLE);
    end
    exp_q.push_back(PPLH_DLE);
    exp_q.push_back(PPLH_ETX);
    foreach (exp_q[i]) b ^= (i > 0) ? exp_q[i] : 8'h00;
    exp_q.push_back(b);
    u_ctrl.seen_q.delete();
    slow <= 1'b1;
    send_net(pl);
    wait_seen(exp_q.size());
    repeat (100) @(posedge clk_sys);
    chk("tx count", u_ctrl.seen_q.size(), exp_q.size());
    foreach (exp_q[i]) chk("tx byte", u_ctrl.seen_q[i], exp_q[i]);
    rd_chk("irq tx", PPLH_R_IRQ, 16'h0004);
    chk("net ready", {15'h0000, net_in_ready}, 16'h0001);
    slow <= 1'b0;
    $display("test tx done");
  endtask
  task automatic t_tmo();
    ack_en <= 1'b0;
    wr(PPLH_R_RETRY, 16'h0001);
    wr(PPLH_R_IRQ, 16'h000F);
    u_ctrl.seen_q.delete();
    send_net('{8'h21});
    repeat (1100) @(posedge clk_sys);
    chk("tmo early", u_ctrl.seen_q.size(), 16'h0001);
    rd_chk("tmo stat", PPLH_R_STAT, 16'h0003);
    repeat (1500) @(posedge clk_sys);
    chk("tmo resend", u_ctrl.seen_q.size(), 16'h0002);
    rd_chk("irq fail", PPLH_R_IRQ, 16'h0008);
    $display("test timeout done");
  endtask
  // Low priority yields to the controller, high priority holds
  task automatic t_coll();
    wr(PPLH_R_RETRY, 16'h0000);
    wr(PPLH_R_IRQ, 16'h000F);
    u_ctrl.seen_q.delete();
    netq.delete();
    send_net('{8'h66});
    wait_seen(1);
    u_ctrl.send(PPLH_STX);
    wait_seen(2);
    chk("coll dle", u_ctrl.seen_q[1], PPLH_DLE);
    ctl_block('{8'h55}, 1'b0);
    wait_seen(4);
    chk("coll ack", u_ctrl.seen_q[2], PPLH_DLE);
    chk("coll restart", u_ctrl.seen_q[3], PPLH_STX);
    chk("coll data", netq[0], 8'h55);
    repeat (1300) @(posedge clk_sys);
    rd_chk("coll irq", PPLH_R_IRQ, 16'h0009);
    wr(PPLH_R_IRQ, 16'h000F);
    wr(PPLH_R_CTRL, 16'h0003);
    u_ctrl.seen_q.delete();
    send_net('{8'h67});
    wait_seen(1);
    u_ctrl.send(PPLH_STX);
    repeat (1500) @(posedge clk_sys);
    chk("high prio", u_ctrl.seen_q.size(), 16'h0001);
    rd_chk("high irq", PPLH_R_IRQ, 16'h0008);
    $display("test collision done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_rx();
    t_bad();
    t_tx();
    t_tmo();
    t_coll();
    report_and_stop();
  end
  // Run needs about 6000 cycles
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
